//--- inc/word_loader_pkg.sv
// constants shared by the serial word loader ends
package word_loader_pkg;
   // ---------------------------------------------------------------
   // word layout
   // ---------------------------------------------------------------
   localparam int WORD_W    = 16;           // bits per frame
   localparam int BYTE_W    = 8;            // bits per burst in byte mode
   localparam int MODE_MSB  = 15;           // select field, upper bits
   localparam int MODE_LSB  = 13;
   localparam int CHAN_MSB  = 12;           // channel field
   localparam int CHAN_LSB  = 10;
   localparam int DATA_W    = 10;           // main converter data width
   localparam int SUB_W     = 8;            // offset sub-converter width
   localparam int MAX_CHAN  = 8;            // channel field reaches eight

   // ---------------------------------------------------------------
   // select codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_SYSTEM  = 3'h0,                   // system control word
      SEL_MAIN    = 3'h1,                   // main converter data
      SEL_CHANNEL = 3'h2,                   // channel control word
      SEL_SUB     = 3'h5                    // offset sub-converter data
   } sel_t;

   // ---------------------------------------------------------------
   // reset values and host timing
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] MAIN_RESET  = 10'h000;  // main level after reset
   localparam logic [SUB_W-1:0]  SUB_RESET   = 8'h00;    // sub level after reset
   localparam logic [DATA_W-1:0] CTRL_RESET  = 10'h000;  // control words after reset
   localparam int                HALF_CYCLES = 2;        // ref cycles per half serial clock
   localparam int                GAP_HALVES  = 4;        // idle halves between bytes
   localparam int                LOAD_HALVES = 2;        // width of a load pulse
endpackage : word_loader_pkg

//--- inc/word_link_if.sv
// three-wire serial link plus load and clear strobes
`timescale 1ns/1ps
interface word_link_if;
   logic serial_clk_in;    // serial clock, made by the host
   logic serial_in;        // serial data, msb first
   logic frame_sync_n;     // frame sync, low while bits flow
   logic load_outputs_n;   // load strobe, low moves inputs to outputs
   logic clear_outputs_n;  // clear strobe, low clears main levels

   // host end drives every wire
   modport host (
      output serial_clk_in,
      output serial_in,
      output frame_sync_n,
      output load_outputs_n,
      output clear_outputs_n
   );

   // device end receives every wire
   modport dev (
      input serial_clk_in,
      input serial_in,
      input frame_sync_n,
      input load_outputs_n,
      input clear_outputs_n
   );
endinterface : word_link_if

//--- rtl/word_loader_dev.sv
// device end: serial word capture and double-buffered channel levels
`timescale 1ns/1ps
module word_loader_dev
   import word_loader_pkg::*;
#(
   parameter int CHANNELS = 4                              // converter channels
) (
   // system clock and reset
   input  wire logic                              ref_clk,
   input  wire logic                              rst,
   // link from the host
   word_link_if.dev                               link,
   // channel levels
   output logic [CHANNELS-1:0][DATA_W-1:0]        main_level,
   output logic [CHANNELS-1:0][SUB_W-1:0]         sub_level,
   output logic [CHANNELS-1:0][DATA_W-1:0]        chan_ctrl,
   output logic [DATA_W-1:0]                      sys_ctrl,
   output logic                                   word_strobe
);
   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   if (CHANNELS < 1 || CHANNELS > MAX_CHAN) begin : g_bad_chan
      $error("CHANNELS must lie between one and eight");
   end

   // ---------------------------------------------------------------
   // word field helpers
   // ---------------------------------------------------------------
   // select code of a word
   function automatic logic [2:0] word_sel(input logic [WORD_W-1:0] w);
      return w[MODE_MSB:MODE_LSB];
   endfunction : word_sel

   // channel number of a word
   function automatic logic [2:0] word_chan(input logic [WORD_W-1:0] w);
      return w[CHAN_MSB:CHAN_LSB];
   endfunction : word_chan

   // ---------------------------------------------------------------
   // link domain
   // ---------------------------------------------------------------
   logic [WORD_W-2:0] shift_reg;     // bits gathered so far
   logic [4:0]        bit_cnt_reg;   // falling edges in this frame
   logic [WORD_W-1:0] word_reg;      // last complete word
   logic              word_tgl_reg;  // toggles once per complete word

   // bit counter, cleared by the frame sync itself since the clock stops
   // partial word dropped
   always_ff @(negedge link.serial_clk_in or posedge rst or posedge link.frame_sync_n) begin
      if (rst || link.frame_sync_n) begin
         bit_cnt_reg <= 5'h00;
      end else if (bit_cnt_reg == 5'(WORD_W - 1)) begin
         bit_cnt_reg <= 5'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
   end

   // shifter, first bit ends up at the top
   // falling edge sampling
   always_ff @(negedge link.serial_clk_in or posedge rst) begin
      if (rst) begin
         shift_reg <= '0;
      end else if (!link.frame_sync_n) begin
         shift_reg <= {shift_reg[WORD_W-3:0], link.serial_in};
      end
   end

   // word capture on every sixteenth falling edge of a frame
   always_ff @(negedge link.serial_clk_in or posedge rst) begin
      if (rst) begin
         word_reg     <= '0;
         word_tgl_reg <= 1'b0;
      end else if (!link.frame_sync_n && bit_cnt_reg == 5'(WORD_W - 1)) begin
         word_reg     <= {shift_reg, link.serial_in};
         word_tgl_reg <= ~word_tgl_reg;
      end
   end

   // ---------------------------------------------------------------
   // crossing into the system domain
   // ---------------------------------------------------------------
   logic [2:0]        tgl_sync_reg;   // toggle synchroniser plus edge stage
   logic [1:0]        load_sync_reg;  // load strobe synchroniser
   logic [1:0]        clr_sync_reg;   // clear strobe synchroniser
   logic              new_word;       // one cycle per arriving word
   logic [WORD_W-1:0] word_cap;       // word, stable while toggle settles

   // synchronisers, stage zero read only by stage one
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tgl_sync_reg  <= 3'h0;
         load_sync_reg <= 2'h3;
         clr_sync_reg  <= 2'h3;
      end else begin
         tgl_sync_reg  <= {tgl_sync_reg[1:0], word_tgl_reg};
         load_sync_reg <= {load_sync_reg[0], link.load_outputs_n};
         clr_sync_reg  <= {clr_sync_reg[0], link.clear_outputs_n};
      end
   end

   // word is quiet for sixteen serial clocks after each toggle
   assign new_word = tgl_sync_reg[2] ^ tgl_sync_reg[1];
   assign word_cap = word_reg;

   // ---------------------------------------------------------------
   // input registers
   // ---------------------------------------------------------------
   logic [CHANNELS-1:0][DATA_W-1:0] main_in_reg;  // main input stage
   logic [CHANNELS-1:0][SUB_W-1:0]  sub_in_reg;   // sub input stage
   logic [2:0]                      sel;          // decoded select
   logic [2:0]                      chan;         // decoded channel

   assign sel  = word_sel(word_cap);
   assign chan = word_chan(word_cap);

   // input stage and control words written by arriving words
   // select and channel decode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         main_in_reg <= {CHANNELS{MAIN_RESET}};
         sub_in_reg  <= {CHANNELS{SUB_RESET}};
         chan_ctrl   <= {CHANNELS{CTRL_RESET}};
         sys_ctrl    <= CTRL_RESET;
      end else if (!clr_sync_reg[1]) begin
         // clear empties the main input stage
         main_in_reg <= {CHANNELS{MAIN_RESET}};
      end else if (new_word) begin
         case (sel)
            SEL_SYSTEM: begin
               sys_ctrl <= word_cap[DATA_W-1:0];
            end
            SEL_MAIN: begin
               if (int'(chan) < CHANNELS) begin
                  main_in_reg[chan] <= word_cap[DATA_W-1:0];
               end
            end
            SEL_CHANNEL: begin
               if (int'(chan) < CHANNELS) begin
                  chan_ctrl[chan] <= word_cap[DATA_W-1:0];
               end
            end
            SEL_SUB: begin
               if (int'(chan) < CHANNELS) begin
                  sub_in_reg[chan] <= word_cap[SUB_W-1:0];
               end
            end
            default: begin
               // unknown select codes are ignored
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   // outputs follow inputs while the load strobe is low
   // load moves all channels
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         main_level <= {CHANNELS{MAIN_RESET}};
         sub_level  <= {CHANNELS{SUB_RESET}};
      end else if (!clr_sync_reg[1]) begin
         main_level <= {CHANNELS{MAIN_RESET}};
      end else if (!load_sync_reg[1]) begin
         main_level <= main_in_reg;
         sub_level  <= sub_in_reg;
      end
   end

   // one pulse per arriving word
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         word_strobe <= 1'b0;
      end else begin
         word_strobe <= new_word;
      end
   end
endmodule : word_loader_dev

//--- rtl/word_loader_host.sv
// host end: word fifo and serial frame generator with divided clock
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,                   // word width
   parameter int DEPTH = 4                     // words held
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two, two or more");
   end

   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];      // storage
   logic [AW:0]      wr_ptr_reg;       // write pointer with wrap bit
   logic [AW:0]      rd_ptr_reg;       // read pointer with wrap bit
   logic             push;             // word enters
   logic             pop;              // word leaves

   assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];

   // storage write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule : word_fifo

module word_loader_host
   import word_loader_pkg::*;
#(
   parameter int FIFO_DEPTH = 4                 // queued words
) (
   // system clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // word stream in
   input  wire logic              word_valid,
   output logic                   word_ready,
   input  wire logic [WORD_W-1:0] word_data,
   // options and strobes
   input  wire logic              byte_mode,    // send as two bursts
   input  wire logic              load_hold,    // keep load strobe low
   input  wire logic              load_req,     // one-cycle load request
   input  wire logic              clear_req,    // level, clear while high
   output logic                   busy,
   // link to the device
   word_link_if.host              link
);
   typedef enum {ST_IDLE, ST_SHIFT, ST_GAP, ST_TAIL, ST_LOAD} host_st_t;

   // ---------------------------------------------------------------
   // queue and half-period tick
   // ---------------------------------------------------------------
   logic              q_valid;          // queued word waiting
   logic [WORD_W-1:0] q_data;           // head of queue
   logic              q_pop;            // head taken
   logic [3:0]        half_cnt_reg;     // ref cycles within a half
   logic              tick;             // last cycle of a half
   host_st_t          st_reg;           // frame state
   logic [WORD_W-1:0] sh_reg;           // outgoing bits
   logic [4:0]        bits_reg;         // bits completed
   logic [3:0]        wait_reg;         // halves waited
   logic              load_pend_reg;    // load request waiting
   logic              sclk_reg;         // serial clock out
   logic              frame_n_reg;      // frame sync out
   logic              load_n_reg;       // load strobe out
   logic              clr_n_reg;        // clear strobe out

   word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (word_valid),
      .in_ready  (word_ready),
      .in_data   (word_data),
      .out_valid (q_valid),
      .out_ready (q_pop),
      .out_data  (q_data)
   );

   assign tick  = half_cnt_reg == 4'(HALF_CYCLES - 1);
   assign q_pop = st_reg == ST_IDLE && tick && q_valid && !load_pend_reg;

   // divider, the serial clock is made from ref_clk
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         half_cnt_reg <= 4'h0;
      end else if (tick) begin
         half_cnt_reg <= 4'h0;
      end else begin
         half_cnt_reg <= half_cnt_reg + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------------
   // one frame at a time, so only one frame sync is ever low
   // single frame sync
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_reg        <= ST_IDLE;
         sh_reg        <= '0;
         bits_reg      <= 5'h00;
         wait_reg      <= 4'h0;
         sclk_reg      <= 1'b1;
         frame_n_reg   <= 1'b1;
         load_pend_reg <= 1'b0;
      end else begin
         if (load_req) begin
            load_pend_reg <= 1'b1;
         end
         if (tick) begin
            case (st_reg)
               ST_IDLE: begin
                  if (load_pend_reg) begin
                     load_pend_reg <= load_req;
                     wait_reg      <= 4'h0;
                     st_reg        <= ST_LOAD;
                  end else if (q_valid) begin
                     sh_reg      <= q_data;
                     bits_reg    <= 5'h00;
                     frame_n_reg <= 1'b0;
                     st_reg      <= ST_SHIFT;
                  end
               end
               ST_SHIFT: begin
                  if (sclk_reg) begin
                     sclk_reg <= 1'b0;
                  end else begin
                     sclk_reg <= 1'b1;
                     sh_reg   <= {sh_reg[WORD_W-2:0], 1'b0};
                     bits_reg <= bits_reg + 5'h01;
                     wait_reg <= 4'h0;
                     if (bits_reg == 5'(WORD_W - 1)) begin
                        st_reg <= ST_TAIL;
                     end else if (byte_mode && bits_reg == 5'(BYTE_W - 1)) begin
                        st_reg <= ST_GAP;
                     end
                  end
               end
               ST_GAP: begin
                  wait_reg <= wait_reg + 4'h1;
                  if (wait_reg == 4'(GAP_HALVES - 1)) begin
                     st_reg <= ST_SHIFT;
                  end
               end
               ST_TAIL: begin
                  frame_n_reg <= 1'b1;
                  st_reg      <= ST_IDLE;
               end
               ST_LOAD: begin
                  wait_reg <= wait_reg + 4'h1;
                  if (wait_reg == 4'(LOAD_HALVES - 1)) begin
                     st_reg <= ST_IDLE;
                  end
               end
               default: begin
                  st_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // strobes
   // ---------------------------------------------------------------
   // load low while held or during a pulse; clear follows its request
   // load pulse ahead of waiting words
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         load_n_reg <= 1'b1;
         clr_n_reg  <= 1'b1;
         busy       <= 1'b0;
      end else begin
         load_n_reg <= !(load_hold || st_reg == ST_LOAD);
         clr_n_reg  <= !clear_req;
         busy       <= st_reg != ST_IDLE || q_valid || load_pend_reg;
      end
   end

   // all link wires come straight from flops, so no glitches
   // glitch free frame sync
   assign link.serial_clk_in   = sclk_reg;
   assign link.serial_in       = sh_reg[WORD_W-1];
   assign link.frame_sync_n    = frame_n_reg;
   assign link.load_outputs_n  = load_n_reg;
   assign link.clear_outputs_n = clr_n_reg;
endmodule : word_loader_host

//--- tb/word_link_checker.sv
// assertions on the serial word link wires
`timescale 1ns/1ps
module word_link_checker
   import word_loader_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // link wires
   input  wire logic serial_clk_in,
   input  wire logic serial_in,
   input  wire logic frame_sync_n
);
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   logic [4:0] falls_reg;  // clock falls seen in this frame
   logic [3:0] high_reg;   // cycles of the current high phase in a frame
   logic       clk_q;      // clock one cycle ago

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // count falls, cleared while the frame is idle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         falls_reg <= '0;
         clk_q     <= 1'b1;
      end else begin
         clk_q <= serial_clk_in;
         if (frame_sync_n) falls_reg <= '0;
         else if (clk_q && !serial_clk_in) falls_reg <= falls_reg + 5'h1;
      end
   end

   // length of the current high phase
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) high_reg <= '0;
      else if (!serial_clk_in || frame_sync_n) high_reg <= '0;
      else if (high_reg != 4'hf) high_reg <= high_reg + 4'h1;
   end

   // ---------------------------------------------------------------
   // link properties
   // ---------------------------------------------------------------
   a_data_on_rise: assert property (!frame_sync_n && $changed(serial_in)
      |-> $rose(serial_clk_in) || $fell(frame_sync_n)) else $error("data moved off a rise");
   a_stable_at_fall: assert property ($fell(serial_clk_in) |-> $stable(serial_in))
      else $error("data moved at a fall");
   a_fall_in_frame: assert property ($fell(serial_clk_in) |-> !frame_sync_n)
      else $error("clock fell outside a frame");
   a_rise_in_frame: assert property ($rose(serial_clk_in) |-> !frame_sync_n)
      else $error("clock rose outside a frame");
   a_idle_clock_high: assert property (frame_sync_n |-> serial_clk_in)
      else $error("clock low while idle");
   a_sixteen_falls: assert property ($rose(frame_sync_n) |-> falls_reg == WORD_W)
      else $error("frame closed without sixteen falls");
   a_low_half: assert property ($fell(serial_clk_in) |=> !serial_clk_in ##1 serial_clk_in)
      else $error("low phase not two cycles");
   a_byte_gap: assert property ($fell(serial_clk_in) && high_reg > 4
      |-> falls_reg == BYTE_W) else $error("long pause not between bytes");
   a_frame_spacing: assert property ($rose(frame_sync_n) |=> frame_sync_n)
      else $error("frame reopened at once");
   a_frame_quiet_clk: assert property ($changed(frame_sync_n)
      |-> serial_clk_in && $stable(serial_clk_in)) else $error("frame sync moved near a clock edge");
endmodule : word_link_checker

//--- tb/tb_top.sv
// self-checking bench: host and device ends joined, plus a spare device link
`timescale 1ns/1ps
module tb_top
   import word_loader_pkg::*;
;
   localparam logic [WORD_W-1:0] EX[4] = '{16'h0060, 16'h4210, 16'h23ff, 16'ha3ff};
   // stimulus
   logic                   ref_clk = 1'b0, lclk = 1'b0, gate = 1'b1, rst = 1'b0;
   logic                   word_valid = 1'b0, byte_mode = 1'b0, load_hold = 1'b0;
   logic                   load_req = 1'b0, clear_req = 1'b0, saw_full = 1'b0;
   logic [WORD_W-1:0]      word_data = '0;
   // design outputs and model state
   logic                   word_ready, busy, word_strobe;
   logic [3:0][DATA_W-1:0] main_level, chan_ctrl, main2, m_in = '0, m_out = '0, c_ctl = '0;
   logic [3:0][SUB_W-1:0]  sub_level, s_in = '0, s_out = '0;
   logic [DATA_W-1:0]      sys_ctrl, sys2, s_sys = '0;
   logic [WORD_W-1:0]      q[$];
   logic [31:0]            lfsr = 32'h3b9440bd;
   int                     failures = 0, n_compared = 0, cycles = 0, n_sent = 0, n_strobes = 0;

   word_link_if link ();
   word_link_if link2 ();
   word_loader_host word_loader_host_inst (.ref_clk(ref_clk), .rst(rst), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data), .byte_mode(byte_mode),
      .load_hold(load_hold), .load_req(load_req), .clear_req(clear_req), .busy(busy),
      .link(link));
   word_loader_dev word_loader_dev_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
      .main_level(main_level), .sub_level(sub_level), .chan_ctrl(chan_ctrl),
      .sys_ctrl(sys_ctrl), .word_strobe(word_strobe));
   word_loader_dev word_loader_dev_inst2 (.ref_clk(ref_clk), .rst(rst), .link(link2),
      .main_level(main2), .sub_level(), .chan_ctrl(), .sys_ctrl(sys2), .word_strobe());
   word_link_checker word_link_checker_inst (.ref_clk(ref_clk), .rst(rst),
      .serial_clk_in(link.serial_clk_in), .serial_in(link.serial_in),
      .frame_sync_n(link.frame_sync_n));

   // clocks: system 20 ns, spare link 32 ns with an odd phase
   always #10 ref_clk = ~ref_clk;
   initial #7 forever #16 lclk = ~lclk;
   // spare link clock stands high outside frames
   assign link2.serial_clk_in = gate | lclk;

   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (word_strobe === 1'b1) n_strobes++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   function automatic logic [WORD_W-1:0] rnd();
      lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'h80200003 : 32'h0);
      return lfsr[15:0] & 16'hefff;  // channels 0..3
   endfunction : rnd

   // model: decode one word, unknown selects ignored
   function automatic void apply(input logic [WORD_W-1:0] w);
      int ch;
      ch = w[CHAN_MSB:CHAN_LSB];
      case (w[MODE_MSB:MODE_LSB])
         SEL_SYSTEM:  s_sys = w[9:0];
         SEL_MAIN:    m_in[ch] = w[9:0];
         SEL_CHANNEL: c_ctl[ch] = w[9:0];
         SEL_SUB:     s_in[ch] = w[7:0];
         default: ;
      endcase
      if (load_hold) begin
         m_out = m_in;
         s_out = s_in;
      end
   endfunction : apply

   // offer a word, valid stays up for back to back pushes
   task automatic push(input logic [WORD_W-1:0] w);
      word_valid <= 1'b1;
      word_data  <= w;
      @(posedge ref_clk);
      while (word_ready !== 1'b1) begin
         saw_full = 1'b1;
         @(posedge ref_clk);
      end
      q.push_back(w);
      n_sent++;
   endtask : push

   // let the host go idle, fold sent words into the model, compare
   task automatic drain();
      int k;
      word_valid <= 1'b0;
      tick(3);
      for (k = 0; k < 2000 && busy !== 1'b0; k++) tick(1);
      check(busy, 1'b0);
      tick(12);
      while (q.size() > 0) apply(q.pop_front());
      check(64'(main_level), 64'(m_out));
      check(64'(sub_level), 64'(s_out));
      check(64'(chan_ctrl), 64'(c_ctl));
      check(64'(sys_ctrl), 64'(s_sys));
   endtask : drain

   // spare link: n bits msb first on lclk, data moves on rises
   task automatic bang(input logic [WORD_W-1:0] w, input int n);
      int i;
      @(posedge lclk);
      gate <= 1'b0;
      link2.frame_sync_n <= 1'b0;
      link2.serial_in <= w[WORD_W-1];
      for (i = 1; i <= n; i++) begin
         @(posedge lclk);
         link2.serial_in <= (i < n) ? w[WORD_W-1-i] : ~link2.serial_in;
      end
      gate <= 1'b1;
      @(posedge lclk);
      link2.frame_sync_n <= 1'b1;
      tick(20);
   endtask : bang

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      rst <= 1'b1;
      link2.frame_sync_n = 1'b1;
      link2.serial_in = 1'b0;
      link2.load_outputs_n = 1'b0;
      link2.clear_outputs_n = 1'b1;
      tick(10);
      rst <= 1'b0;
      load_hold <= 1'b1;
      tick(2);
      foreach (EX[i]) begin
         push(EX[i]);
         drain();
      end
      $display("test example words done");
      for (int i = 0; i < 8; i++) push(rnd());
      drain();
      check(saw_full, 1'b1);
      $display("test burst done");
      byte_mode <= 1'b1;
      for (int i = 0; i < 4; i++) push(rnd());
      drain();
      byte_mode <= 1'b0;
      $display("test byte bursts done");
      load_hold <= 1'b0;
      tick(2);
      for (int i = 0; i < 4; i++) push(rnd() | 16'h2000);
      drain();
      load_req <= 1'b1;
      tick(1);
      load_req <= 1'b0;
      m_out = m_in;
      s_out = s_in;
      drain();
      check(64'(main_level), 64'(m_in));
      $display("test double buffer done");
      clear_req <= 1'b1;
      tick(10);
      m_in = '0;
      m_out = '0;
      check(64'(main_level), 64'(m_out));
      clear_req <= 1'b0;
      $display("test clear done");
      bang(16'h23ff, 15);
      bang(16'h0060, 16);
      check(64'(main2), 64'h0);
      check(64'(sys2), 64'h060);
      bang(16'h23ff, 16);
      check(64'(main2), 64'h3ff);
      $display("test spare link done");
      check(n_strobes, n_sent);
      tally_and_finish();
   end
endmodule : tb_top
